// [core/tcc_pkg.sv]
// Constants for the 16-bit timer counter and input capture block
// What this block does
// - Clock source select of zero stops the counter.
// - Sixteen-bit counter clears, increments or decrements per tick by mode.
// - CPU write to the counter beats a same-cycle clear or count.
// - CPU reads and writes the counter whether ticks run or not.
// - Low-byte read copies high byte to holding register; high location hits holding.
// - Low-byte write loads holding register and written byte together.
// - Holding register survives low-byte writes for reuse.
// - Overflow flag set at the mode's point and can interrupt.
// - Qualifying edge copies counter to capture register and sets flag together.
// - Capture interrupt while flag and enable; cleared by acknowledge or written one.
// - Capture register read low byte first through the holding register.
// - Capture register writable only in capture-top modes, high byte first.
// - Select bit switches trigger to comparator; software clears flag afterwards.
// - Filter changes output only after four equal samples.
// - Filter samples on the undivided system clock.
// - Filter and edge detector keep running in capture-top modes; only the capture event is gated.
// - Capture pin uses the external tick pin synchroniser.
// - Each new event overwrites the capture register.
// - Top is 0xFFFF, 0x00FF, 0x01FF, 0x03FF, compare A or capture register.
package tcc_pkg;
  // ----------------------------------------
  // Register offsets on the 8-bit I/O port
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] ADDR_CNT_LO = 4'h2;
  localparam logic [3:0] ADDR_CNT_HI = 4'h3;
  localparam logic [3:0] ADDR_CAP_LO = 4'h4;
  localparam logic [3:0] ADDR_CAP_HI = 4'h5;
  localparam logic [3:0] ADDR_FLAGS = 4'h6;
  localparam logic [3:0] ADDR_MASK = 4'h7;
  localparam logic [3:0] ADDR_CMP_CTRL = 4'h8;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_FILTER_EN = 7;
  localparam int BIT_EDGE_SEL = 6;
  localparam int BIT_CAP_FLAG = 5;
  localparam int BIT_OVF_FLAG = 0;
  localparam int BIT_CMP_SEL = 2;
  // ----------------------------------------
  // Reset values and fixed figures
  // ----------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [2:0] CLK_STOPPED = 3'h0;
  localparam int FILTER_LEN = 4;
  // Modes whose top comes from the capture register
  localparam logic [3:0] MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] MODE_PC_CAP = 4'hA;
  localparam logic [3:0] MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] MODE_FAST_CAP = 4'hE;
endpackage

// [core/tcc_sync2.sv]
// Two-stage synchroniser shared by the tick pin style inputs
`timescale 1ns/10ps
`default_nettype none
module tcc_sync2 (
  input wire logic mclk,
  input wire logic rstSync_n,
  input wire logic asyncIn,
  output logic syncOut
);
  logic stage1;

  // First stage feeds only the second
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      stage1 <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule
`default_nettype wire

// [core/tcc_noise_filter.sv]
// Four-sample noise filter ahead of the capture edge detector
`timescale 1ns/10ps
`default_nettype none
module tcc_noise_filter (
  input wire logic mclk,
  input wire logic rstSync_n,
  input wire logic enable,
  input wire logic sampleIn,
  output logic filtOut
);
  localparam int LEN = tcc_pkg::FILTER_LEN;
  logic [LEN-1:0] hist;

  // Sample every system clock, so the prescaler has no say
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      hist <= '0;
    end else begin
      hist <= {hist[LEN-2:0], sampleIn};
    end
  end

  // Output only moves when the whole window agrees
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      filtOut <= 1'b0;
    end else if (!enable) begin
      filtOut <= sampleIn;
    end else if (&hist) begin
      filtOut <= 1'b1;
    end else if (~|hist) begin
      filtOut <= 1'b0;
    end
  end

  property p_filtAgree;
    @(posedge mclk) disable iff (!rstSync_n)
      enable && $past(enable) && $changed(filtOut)
        |-> ($past(hist) == {LEN{filtOut}});
  endproperty
  a_filtAgree: assert property (p_filtAgree)
    else $error("filter output moved without four equal samples");
endmodule
`default_nettype wire

// [core/tcc_timer16_capture.sv]
// Counter unit and input capture unit of the 16-bit timer
`timescale 1ns/10ps
`default_nettype none
module tcc_timer16_capture (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] ioAddr,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [7:0] ioWdata,
  output logic [7:0] ioRdata,
  input wire logic timerTick,
  input wire logic capturePin,
  input wire logic comparatorOutput,
  input wire logic [15:0] compareAValue,
  input wire logic captureIrqAck,
  input wire logic overflowIrqAck,
  output logic [15:0] countValue,
  output logic captureIrq,
  output logic overflowIrq
);
  logic rstMeta_n;
  logic rstSync_n;
  logic [7:0] timerControlA;
  logic [7:0] timerControlB;
  logic [7:0] holdHigh;
  logic [15:0] capturedValue;
  logic captureFlag;
  logic overflowFlag;
  logic captureIrqEnable;
  logic overflowIrqEnable;
  logic comparatorCaptureSelect;
  logic countDown;
  logic pinSync;
  logic cmpSync;
  logic filtered;
  logic filtPrev;
  logic [3:0] waveMode;
  logic [2:0] clockSourceSelect;
  logic [15:0] topValue;
  logic dualSlope;
  logic ovfAtTop;
  logic ovfAtBottom;
  logic captureTop;
  logic countStep;
  logic captureEvent;
  logic overflowEvent;
  logic wrCntLo;
  logic rdCntLo;
  logic wrCapLo;
  logic [15:0] next_count;
  logic next_countDown;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  // Reset asserts at once but leaves through two flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  assign waveMode = {timerControlB[4:3], timerControlA[1:0]};
  assign clockSourceSelect = timerControlB[2:0];
  assign captureTop = (waveMode == tcc_pkg::MODE_PFC_CAP)
    || (waveMode == tcc_pkg::MODE_PC_CAP)
    || (waveMode == tcc_pkg::MODE_CTC_CAP)
    || (waveMode == tcc_pkg::MODE_FAST_CAP);

  // Top value, slope and overflow point for each mode
  always_comb begin
    topValue = tcc_pkg::COUNT_MAX;
    dualSlope = 1'b0;
    ovfAtTop = 1'b0;
    ovfAtBottom = 1'b0;
    case (waveMode)
      4'h1: begin
        topValue = tcc_pkg::TOP_8BIT;
        dualSlope = 1'b1;
        ovfAtBottom = 1'b1;
      end
      4'h2: begin
        topValue = tcc_pkg::TOP_9BIT;
        dualSlope = 1'b1;
        ovfAtBottom = 1'b1;
      end
      4'h3: begin
        topValue = tcc_pkg::TOP_10BIT;
        dualSlope = 1'b1;
        ovfAtBottom = 1'b1;
      end
      4'h4: topValue = compareAValue;
      4'h5: begin
        topValue = tcc_pkg::TOP_8BIT;
        ovfAtTop = 1'b1;
      end
      4'h6: begin
        topValue = tcc_pkg::TOP_9BIT;
        ovfAtTop = 1'b1;
      end
      4'h7: begin
        topValue = tcc_pkg::TOP_10BIT;
        ovfAtTop = 1'b1;
      end
      4'h8, 4'hA: begin
        topValue = capturedValue;
        dualSlope = 1'b1;
        ovfAtBottom = 1'b1;
      end
      4'h9, 4'hB: begin
        topValue = compareAValue;
        dualSlope = 1'b1;
        ovfAtBottom = 1'b1;
      end
      4'hC: topValue = capturedValue;
      4'hE: begin
        topValue = capturedValue;
        ovfAtTop = 1'b1;
      end
      4'hF: begin
        topValue = compareAValue;
        ovfAtTop = 1'b1;
      end
      default: topValue = tcc_pkg::COUNT_MAX;
    endcase
  end

  // ----------------------------------------
  // Access strobes
  // ----------------------------------------
  assign wrCntLo = ioWrite && (ioAddr == tcc_pkg::ADDR_CNT_LO);
  assign rdCntLo = ioRead && (ioAddr == tcc_pkg::ADDR_CNT_LO);
  assign wrCapLo = ioWrite && (ioAddr == tcc_pkg::ADDR_CAP_LO);
  // Stopped clock select masks the tick from the outside prescaler
  assign countStep = timerTick
    && (clockSourceSelect != tcc_pkg::CLK_STOPPED);

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Next count for one tick in the current mode
  always_comb begin
    next_count = countValue;
    next_countDown = countDown;
    if (!dualSlope) begin
      next_count = (countValue == topValue) ? tcc_pkg::RESET_WORD
        : countValue + 16'h0001;
    end else if (countDown) begin
      if (countValue == tcc_pkg::RESET_WORD) begin
        next_count = countValue + 16'h0001;
        next_countDown = 1'b0;
      end else begin
        next_count = countValue - 16'h0001;
      end
    end else if (countValue >= topValue) begin
      next_count = countValue - 16'h0001;
      next_countDown = 1'b1;
    end else begin
      next_count = countValue + 16'h0001;
    end
  end

  // CPU low-byte write wins over any tick in the same cycle
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      countValue <= tcc_pkg::RESET_WORD;
      countDown <= 1'b0;
    end else if (wrCntLo) begin
      countValue <= {holdHigh, ioWdata};
    end else if (countStep) begin
      countValue <= next_count;
      countDown <= next_countDown;
    end
  end

  assign overflowEvent = countStep && !wrCntLo
    && ((ovfAtTop && countValue == topValue)
    || (ovfAtBottom && countDown && countValue == tcc_pkg::RESET_WORD)
    || (!ovfAtTop && !ovfAtBottom
    && countValue == tcc_pkg::COUNT_MAX));

  // ----------------------------------------
  // Shared high-byte holding register
  // ----------------------------------------
  // Low-byte writes leave it alone so one high write serves many
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      holdHigh <= tcc_pkg::RESET_BYTE;
    end else if (ioWrite && (ioAddr == tcc_pkg::ADDR_CNT_HI
        || ioAddr == tcc_pkg::ADDR_CAP_HI)) begin
      holdHigh <= ioWdata;
    end else if (rdCntLo) begin
      holdHigh <= countValue[15:8];
    end else if (ioRead && ioAddr == tcc_pkg::ADDR_CAP_LO) begin
      holdHigh <= capturedValue[15:8];
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      timerControlA <= tcc_pkg::RESET_BYTE;
      timerControlB <= tcc_pkg::RESET_BYTE;
      captureIrqEnable <= 1'b0;
      overflowIrqEnable <= 1'b0;
      comparatorCaptureSelect <= 1'b0;
    end else if (ioWrite) begin
      if (ioAddr == tcc_pkg::ADDR_CTRL_A) begin
        timerControlA <= ioWdata;
      end else if (ioAddr == tcc_pkg::ADDR_CTRL_B) begin
        timerControlB <= ioWdata;
      end else if (ioAddr == tcc_pkg::ADDR_MASK) begin
        captureIrqEnable <= ioWdata[tcc_pkg::BIT_CAP_FLAG];
        overflowIrqEnable <= ioWdata[tcc_pkg::BIT_OVF_FLAG];
      end else if (ioAddr == tcc_pkg::ADDR_CMP_CTRL) begin
        comparatorCaptureSelect <= ioWdata[tcc_pkg::BIT_CMP_SEL];
      end
    end
  end

  // ----------------------------------------
  // Trigger path
  // ----------------------------------------
  // Same synchroniser as the external tick pin, so port writes trigger
  tcc_sync2 u_pinSync (
    .mclk(mclk),
    .rstSync_n(rstSync_n),
    .asyncIn(capturePin),
    .syncOut(pinSync)
  );

  tcc_sync2 u_cmpSync (
    .mclk(mclk),
    .rstSync_n(rstSync_n),
    .asyncIn(comparatorOutput),
    .syncOut(cmpSync)
  );

  tcc_noise_filter u_filter (
    .mclk(mclk),
    .rstSync_n(rstSync_n),
    .enable(timerControlB[tcc_pkg::BIT_FILTER_EN]),
    .sampleIn(comparatorCaptureSelect ? cmpSync : pinSync),
    .filtOut(filtered)
  );

  // Edge history keeps tracking; only the event is gated by mode
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      filtPrev <= 1'b0;
    end else begin
      filtPrev <= filtered;
    end
  end

  // A source switch can look like an edge; software clears after
  assign captureEvent = !captureTop && (filtered != filtPrev)
    && (filtered == timerControlB[tcc_pkg::BIT_EDGE_SEL]);

  // ----------------------------------------
  // Capture register and flags
  // ----------------------------------------
  // Unread values are lost on the next event by design
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      capturedValue <= tcc_pkg::RESET_WORD;
    end else if (captureEvent) begin
      capturedValue <= countValue;
    end else if (wrCapLo && captureTop) begin
      capturedValue <= {holdHigh, ioWdata};
    end
  end

  // A set in the same cycle as a clear wins
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      captureFlag <= 1'b0;
      overflowFlag <= 1'b0;
    end else begin
      if (captureEvent) begin
        captureFlag <= 1'b1;
      end else if (captureIrqAck || (ioWrite && ioAddr == tcc_pkg::ADDR_FLAGS
          && ioWdata[tcc_pkg::BIT_CAP_FLAG])) begin
        captureFlag <= 1'b0;
      end
      if (overflowEvent) begin
        overflowFlag <= 1'b1;
      end else if (overflowIrqAck || (ioWrite
          && ioAddr == tcc_pkg::ADDR_FLAGS
          && ioWdata[tcc_pkg::BIT_OVF_FLAG])) begin
        overflowFlag <= 1'b0;
      end
    end
  end

  // Requests follow flag and enable one cycle later
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      captureIrq <= 1'b0;
      overflowIrq <= 1'b0;
    end else begin
      captureIrq <= captureFlag && captureIrqEnable;
      overflowIrq <= overflowFlag && overflowIrqEnable;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Data answers one cycle after the read strobe
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ioRdata <= tcc_pkg::RESET_BYTE;
    end else if (ioRead) begin
      if (ioAddr == tcc_pkg::ADDR_CTRL_A) begin
        ioRdata <= timerControlA;
      end else if (ioAddr == tcc_pkg::ADDR_CTRL_B) begin
        ioRdata <= timerControlB;
      end else if (ioAddr == tcc_pkg::ADDR_CNT_LO) begin
        ioRdata <= countValue[7:0];
      end else if (ioAddr == tcc_pkg::ADDR_CNT_HI
          || ioAddr == tcc_pkg::ADDR_CAP_HI) begin
        ioRdata <= holdHigh;
      end else if (ioAddr == tcc_pkg::ADDR_CAP_LO) begin
        ioRdata <= capturedValue[7:0];
      end else if (ioAddr == tcc_pkg::ADDR_FLAGS) begin
        ioRdata <= {2'b00, captureFlag, 4'h0, overflowFlag};
      end else if (ioAddr == tcc_pkg::ADDR_MASK) begin
        ioRdata <= {2'b00, captureIrqEnable, 4'h0, overflowIrqEnable};
      end else if (ioAddr == tcc_pkg::ADDR_CMP_CTRL) begin
        ioRdata <= {5'h00, comparatorCaptureSelect, 2'b00};
      end else begin
        ioRdata <= tcc_pkg::RESET_BYTE;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstSync_n);

  sequence s_lowRead;
    rdCntLo ##1 1'b1;
  endsequence
  property p_lowReadHold;
    rdCntLo && !ioWrite |=> holdHigh == $past(countValue[15:8]);
  endproperty
  a_lowReadHold: assert property (p_lowReadHold)
    else $error("low read did not latch counter high byte");
  property p_hiReadTemp;
    s_lowRead ##0 (ioRead && ioAddr == tcc_pkg::ADDR_CNT_HI)
      |=> ioRdata == $past(countValue[15:8], 2);
  endproperty
  a_hiReadTemp: assert property (p_hiReadTemp)
    else $error("high read did not return latched byte");
  property p_writeWins;
    wrCntLo |=> countValue == {$past(holdHigh), $past(ioWdata)};
  endproperty
  a_writeWins: assert property (p_writeWins)
    else $error("counter write lost to tick");
  property p_holdKeep;
    wrCntLo |=> $stable(holdHigh);
  endproperty
  a_holdKeep: assert property (p_holdKeep)
    else $error("holding register changed on low write");
  property p_stopped;
    clockSourceSelect == tcc_pkg::CLK_STOPPED && !wrCntLo
      |=> $stable(countValue);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("counter moved with clock stopped");
  property p_capture;
    captureEvent |=> capturedValue == $past(countValue) && captureFlag;
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not copy counter and set flag");
  property p_capIrq;
    captureFlag && captureIrqEnable |=> captureIrq;
  endproperty
  a_capIrq: assert property (p_capIrq)
    else $error("capture request missing");
  property p_capAck;
    captureIrqAck && !captureEvent |=> !captureFlag ##1 !captureIrq;
  endproperty
  a_capAck: assert property (p_capAck)
    else $error("acknowledge did not clear capture flag");
  property p_capWriteGuard;
    wrCapLo && !captureTop && !captureEvent |=> $stable(capturedValue);
  endproperty
  a_capWriteGuard: assert property (p_capWriteGuard)
    else $error("capture register written outside capture-top mode");
  property p_noCapInTop;
    captureTop && !wrCapLo
      |=> $stable(capturedValue) && !$rose(captureFlag);
  endproperty
  a_noCapInTop: assert property (p_noCapInTop)
    else $error("capture fired in capture-top mode");
  property p_overflow;
    countStep && !wrCntLo && waveMode == 4'h0
      && countValue == tcc_pkg::COUNT_MAX
      |=> overflowFlag && countValue == tcc_pkg::RESET_WORD;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("normal mode wrap did not set overflow");
  property p_singleWrap;
    countStep && !wrCntLo && !dualSlope && countValue == topValue
      |=> countValue == tcc_pkg::RESET_WORD;
  endproperty
  a_singleWrap: assert property (p_singleWrap)
    else $error("counter did not clear at top");
endmodule
`default_nettype wire

// [sim/tcc_event_src.sv]
// Behavioural source of capture events on the pin and the comparator
`timescale 1ns/10ps
`default_nettype none
module tcc_event_src (
  input wire logic mclk,
  output var logic capturePin,
  output var logic comparatorOutput
);
  // Both event lines idle low until a scenario moves them
  initial begin
    capturePin = 1'b0;
    comparatorOutput = 1'b0;
  end

  // Pin moves just after an edge, like every other bench input
  task automatic setPin(input logic v);
    @(posedge mclk);
    capturePin <= v;
  endtask

  // Comparator result changes on the same grid as the pin
  task automatic setCmp(input logic v);
    @(posedge mclk);
    comparatorOutput <= v;
  endtask
endmodule
`default_nettype wire

// [sim/tcc_timer16_capture_tb.sv]
// Self-checking bench for the timer counter and capture block
`timescale 1ns/10ps
`default_nettype none
module tcc_timer16_capture_tb;
  logic mclk, reset_n, ioWrite, ioRead, timerTick;
  logic [3:0] ioAddr;
  logic [7:0] ioWdata, ioRdata;
  logic captureIrqAck, overflowIrqAck, captureIrq, overflowIrq;
  logic capturePin, comparatorOutput;
  logic [15:0] compareAValue, countValue, rdWord;
  int numErrors = 0;
  int checksDone = 0;
  int cycles = 0;

  tcc_timer16_capture u_tcc_timer16_capture (
    .mclk(mclk), .reset_n(reset_n), .ioAddr(ioAddr), .ioWrite(ioWrite),
    .ioRead(ioRead), .ioWdata(ioWdata), .ioRdata(ioRdata),
    .timerTick(timerTick), .capturePin(capturePin),
    .comparatorOutput(comparatorOutput), .compareAValue(compareAValue),
    .captureIrqAck(captureIrqAck), .overflowIrqAck(overflowIrqAck),
    .countValue(countValue), .captureIrq(captureIrq),
    .overflowIrq(overflowIrq)
  );
  tcc_event_src u_tcc_event_src (
    .mclk(mclk), .capturePin(capturePin),
    .comparatorOutput(comparatorOutput)
  );

  // ----------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic testDone();
    $display("mismatches %0d comparisons %0d", numErrors, checksDone);
    if (numErrors == 0 && checksDone > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Whole run needs under 1500 cycles; a hang ends well past that
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      numErrors++;
      testDone();
    end
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] seen, exp);
    checksDone++;
    if (seen !== exp) begin
      numErrors++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    ioAddr <= a;
    ioWdata <= d;
    ioWrite <= 1'b1;
    @(posedge mclk);
    ioWrite <= 1'b0;
    #1;
  endtask

  // Read data is sampled one edge late, where it is stable either way
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    ioAddr <= a;
    ioRead <= 1'b1;
    @(posedge mclk);
    ioRead <= 1'b0;
    @(posedge mclk);
    #1 rdWord = {8'h00, ioRdata};
  endtask

  task automatic rc(input string n, input logic [3:0] a, logic [15:0] e);
    rd(a);
    chk(n, rdWord, e);
  endtask

  // Low byte then high location on back-to-back edges, as software does
  task automatic r16(input string n, input logic [3:0] a, logic [15:0] e);
    logic [7:0] lo;
    @(posedge mclk);
    ioAddr <= a;
    ioRead <= 1'b1;
    @(posedge mclk);
    ioAddr <= a + 4'h1;
    #1 lo = ioRdata;
    @(posedge mclk);
    ioRead <= 1'b0;
    #1 chk(n, {ioRdata, lo}, e);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      timerTick <= 1'b1;
      @(posedge mclk);
      timerTick <= 1'b0;
    end
    #1;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {ioWrite, ioRead, timerTick, captureIrqAck, overflowIrqAck} = '0;
    ioAddr = 4'h0;
    ioWdata = 8'h00;
    compareAValue = 16'h0100;
    reset_n = 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk("count reset", countValue, 16'h0000);
    rc("flags reset", tcc_pkg::ADDR_FLAGS, 16'h0000);
    rc("unmapped", 4'hF, 16'h0000);
    // Counter access with no tick source
    wr(tcc_pkg::ADDR_CNT_HI, 8'h12);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h34);
    chk("count write", countValue, 16'h1234);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h56);
    chk("hold reuse", countValue, 16'h1256);
    r16("count read", tcc_pkg::ADDR_CNT_LO, 16'h1256);
    tick(3);
    chk("stopped", countValue, 16'h1256);
    wr(tcc_pkg::ADDR_CTRL_B, 8'h01);
    tick(3);
    chk("counting", countValue, 16'h1259);
    // Write and tick on one edge: the write must win
    @(posedge mclk);
    ioAddr <= tcc_pkg::ADDR_CNT_LO;
    ioWdata <= 8'hAA;
    ioWrite <= 1'b1;
    timerTick <= 1'b1;
    @(posedge mclk);
    ioWrite <= 1'b0;
    timerTick <= 1'b0;
    #1 chk("write priority", countValue, 16'h12AA);
    // Overflow from the top of the normal sequence
    wr(tcc_pkg::ADDR_CNT_HI, 8'hFF);
    wr(tcc_pkg::ADDR_CNT_LO, 8'hFF);
    wr(tcc_pkg::ADDR_MASK, 8'h21);
    tick(1);
    chk("wrap", countValue, 16'h0000);
    rc("ovf flag", tcc_pkg::ADDR_FLAGS, 16'h0001);
    chk("ovf irq", {15'h0000, overflowIrq}, 16'h0001);
    @(posedge mclk);
    overflowIrqAck <= 1'b1;
    @(posedge mclk);
    overflowIrqAck <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk("ovf ack", {15'h0000, overflowIrq}, 16'h0000);
    // Rising capture, falling capture, then two falling captures without reading in between
    wr(tcc_pkg::ADDR_CTRL_B, 8'h40);
    wr(tcc_pkg::ADDR_CNT_HI, 8'h5A);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h01);
    wr(tcc_pkg::ADDR_FLAGS, 8'h21);
    u_tcc_event_src.setPin(1'b1);
    repeat (10) @(posedge mclk);
    #1 chk("cap irq", {15'h0000, captureIrq}, 16'h0001);
    rc("cap flag", tcc_pkg::ADDR_FLAGS, 16'h0020);
    r16("cap rise", tcc_pkg::ADDR_CAP_LO, 16'h5A01);
    wr(tcc_pkg::ADDR_CTRL_B, 8'h00);
    wr(tcc_pkg::ADDR_FLAGS, 8'h20);
    repeat (3) @(posedge mclk);
    #1 chk("cap clear", {15'h0000, captureIrq}, 16'h0000);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h02);
    u_tcc_event_src.setPin(1'b0);
    repeat (10) @(posedge mclk);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h09);
    u_tcc_event_src.setPin(1'b1);
    repeat (10) @(posedge mclk);
    r16("cap fall", tcc_pkg::ADDR_CAP_LO, 16'h5A02);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h0A);
    u_tcc_event_src.setPin(1'b0);
    repeat (10) @(posedge mclk);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h03);
    u_tcc_event_src.setPin(1'b1);
    repeat (10) @(posedge mclk);
    u_tcc_event_src.setPin(1'b0);
    repeat (10) @(posedge mclk);
    r16("overwrite", tcc_pkg::ADDR_CAP_LO, 16'h5A03);
    @(posedge mclk);
    captureIrqAck <= 1'b1;
    @(posedge mclk);
    captureIrqAck <= 1'b0;
    rc("cap ack", tcc_pkg::ADDR_FLAGS, 16'h0000);
    // Filter on: a three-cycle glitch is dropped, a steady level is taken
    wr(tcc_pkg::ADDR_CTRL_B, 8'hC0);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h04);
    u_tcc_event_src.setPin(1'b1);
    repeat (2) @(posedge mclk);
    u_tcc_event_src.setPin(1'b0);
    repeat (15) @(posedge mclk);
    rc("glitch", tcc_pkg::ADDR_FLAGS, 16'h0000);
    u_tcc_event_src.setPin(1'b1);
    repeat (15) @(posedge mclk);
    rc("filtered", tcc_pkg::ADDR_FLAGS, 16'h0020);
    r16("filt cap", tcc_pkg::ADDR_CAP_LO, 16'h5A04);
    // Comparator as trigger, flag cleared after switching
    wr(tcc_pkg::ADDR_CTRL_B, 8'h40);
    wr(tcc_pkg::ADDR_FLAGS, 8'h20);
    u_tcc_event_src.setCmp(1'b1);
    repeat (10) @(posedge mclk);
    rc("cmp unsel", tcc_pkg::ADDR_FLAGS, 16'h0000);
    wr(tcc_pkg::ADDR_CMP_CTRL, 8'h04);
    wr(tcc_pkg::ADDR_FLAGS, 8'h20);
    u_tcc_event_src.setCmp(1'b0);
    repeat (6) @(posedge mclk);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h05);
    u_tcc_event_src.setCmp(1'b1);
    repeat (10) @(posedge mclk);
    r16("cmp cap", tcc_pkg::ADDR_CAP_LO, 16'h5A05);
    // Capture register writes refused in mode 0, taken in a top mode
    wr(tcc_pkg::ADDR_CMP_CTRL, 8'h00);
    wr(tcc_pkg::ADDR_CAP_HI, 8'h77);
    wr(tcc_pkg::ADDR_CAP_LO, 8'h88);
    r16("cap ro", tcc_pkg::ADDR_CAP_LO, 16'h5A05);
    wr(tcc_pkg::ADDR_CTRL_B, 8'h18);
    wr(tcc_pkg::ADDR_FLAGS, 8'h20);
    wr(tcc_pkg::ADDR_CAP_HI, 8'h77);
    wr(tcc_pkg::ADDR_CAP_LO, 8'h88);
    r16("cap top", tcc_pkg::ADDR_CAP_LO, 16'h7788);
    u_tcc_event_src.setPin(1'b0);
    repeat (10) @(posedge mclk);
    rc("top gated", tcc_pkg::ADDR_FLAGS, 16'h0000);
    // Compare A as top in the clear-on-match mode, no overflow there
    @(posedge mclk);
    compareAValue <= 16'h0010;
    wr(tcc_pkg::ADDR_CTRL_B, 8'h09);
    wr(tcc_pkg::ADDR_CNT_HI, 8'h00);
    wr(tcc_pkg::ADDR_CNT_LO, 8'h0F);
    tick(1);
    chk("cmp a step", countValue, 16'h0010);
    tick(1);
    chk("cmp a top", countValue, 16'h0000);
    rc("cmp a no ovf", tcc_pkg::ADDR_FLAGS, 16'h0000);
    testDone();
  end
endmodule
`default_nettype wire
